// *** hw/crd_consts.svh ***
// Offsets, field positions, reset values and timing counts of the rate divider control
`ifndef CRD_CONSTS_SVH
`define CRD_CONSTS_SVH

// Register byte addresses on the Wishbone slave
`define CRD_CFG_OFS        8'h00
`define CRD_STAT_OFS       8'h04
`define CRD_SUPP_OFS       8'h08

// Configuration register fields
`define CRD_CFG_HALF_BIT   0
`define CRD_CFG_QUART_BIT  1
`define CRD_CFG_RST        2'h0

// Status register fields
`define CRD_STAT_MULT_LSB  0
`define CRD_STAT_MODE_LSB  8
`define CRD_STAT_PINS_LSB  12
`define CRD_STAT_STRAP_LSB 16

// Strap width and synchroniser depth
`define CRD_STRAP_W        6
`define CRD_SYNC_STAGES    2

// Ratio change latency in core cycles
`define CRD_SWITCH_CYC     1

`endif

// *** hw/crd_pkg.sv ***
// Types shared by the rate divider control files
package crd_pkg;

  // Division mode in effect
  typedef enum logic [1:0]
  {
    CRD_FULL    = 2'b00,
    CRD_HALF    = 2'b01,
    CRD_QUARTER = 2'b10
  } crd_mode_type;

endpackage

// *** hw/crd_sync.sv ***
// Two-stage synchroniser for a bank of asynchronous pins
`timescale 1ns/100ps

module crd_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Asynchronous inputs, reset value, synchronised outputs
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Next values; the first stage feeds only the second
  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
    if (rst_i)
    begin
      meta_d = rst_val_i;
      sync_d = rst_val_i;
    end
  end

  // Both stages registered on every edge
  always_ff @(posedge clk_i)
  begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign sync_o = sync_q;

endmodule

// *** hw/crd_rate_ctrl.sv ***
// Core-to-bus ratio divider control with Wishbone register access
// Notes on behaviour
// - Half request divides bus ratio by two
// - Clearing half request restores full ratio
// - Quarter request divides bus ratio by four
// - Ratio changes within one cycle, no idle
// - Any asserted pin overrides software bits
// - Both pins asserted disables division entirely
// - Strap latched at reset decides available modes
// - Unsupported request keeps present multiplier
// - Unsupported from undivided stays at strap value
// - Half to unsupported quarter stays at half
// - Readback field shows multiplier in effect
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`include "crd_consts.svh"

module crd_rate_ctrl
  import crd_pkg::*;
#(
  parameter int                    MW        = 8,
  parameter logic [`CRD_STRAP_W-1:0] HALF_OK_MASK = 6'h3F,
  parameter logic [`CRD_STRAP_W-1:0] QUART_OK_MASK = 6'h3F
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone slave
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  // Board pins, active low, asynchronous
  input  wire logic                    half_rate_request_n_i,
  input  wire logic                    quarter_rate_request_n_i,
  // Multiplier strap, sampled while reset is high
  input  wire logic [`CRD_STRAP_W-1:0] mult_strap_i,
  // Rate outputs
  output logic      [1:0]              rate_mode_o,
  output logic      [MW-1:0]           current_multiplier_field_o
);

  // Support table: a mode is offered when the strap is nonzero and each set strap bit
  // is also set in the mask; the table is a parameter since it is board-specific
  function automatic logic mode_ok(input logic [`CRD_STRAP_W-1:0] mask,
                                   input logic [`CRD_STRAP_W-1:0] strap);
    mode_ok = (strap != '0) && ((strap & mask) == strap);
  endfunction

  // Effective multiplier (in halves) for a strap value and a mode
  function automatic logic [MW-1:0] mult_of(input logic [`CRD_STRAP_W-1:0] strap,
                                            input crd_mode_type              mode);
    logic [MW-1:0] base;
    base = MW'(strap);
    unique case (mode)
      CRD_HALF:    mult_of = base >> 1;
      CRD_QUARTER: mult_of = base >> 2;
      default:     mult_of = base;
    endcase
  endfunction

  logic [1:0]              pins_n;
  logic [`CRD_STRAP_W-1:0] strap_q;
  logic [`CRD_STRAP_W-1:0] strap_d;
  logic [1:0]              cfg_q;
  logic [1:0]              cfg_d;
  crd_mode_type            mode_q;
  crd_mode_type            mode_d;
  logic [MW-1:0]           mult_q;
  logic [MW-1:0]           mult_d;
  logic                    ack_q;
  logic                    ack_d;
  logic [31:0]             rdat_q;
  logic [31:0]             rdat_d;
  logic                    half_ok;
  logic                    quart_ok;
  logic                    pin_half;
  logic                    pin_quart;
  logic                    want_half;
  logic                    want_quart;
  crd_mode_type            req_mode;

  // Pins pass two flops before any decode
  crd_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .async_i   ({quarter_rate_request_n_i, half_rate_request_n_i}),
    .rst_val_i (2'h3),
    .sync_o    (pins_n)
  );

  assign pin_half  = ~pins_n[0];
  assign pin_quart = ~pins_n[1];
  assign half_ok   = mode_ok(HALF_OK_MASK, strap_q);
  assign quart_ok  = mode_ok(QUART_OK_MASK, strap_q);

  // Request arbitration: pins beat software, both pins disable
  always_comb
  begin
    if (pin_half || pin_quart)
    begin
      want_half  = pin_half && !pin_quart;
      want_quart = pin_quart && !pin_half;
    end
    else
    begin
      want_half  = cfg_q[`CRD_CFG_HALF_BIT];
      want_quart = cfg_q[`CRD_CFG_QUART_BIT];
    end
    // Quarter wins when software sets both bits
    if (want_quart)
      req_mode = CRD_QUARTER;
    else if (want_half)
      req_mode = CRD_HALF;
    else
      req_mode = CRD_FULL;
  end

  // Mode next value; unsupported targets leave the mode unchanged
  always_comb
  begin
    mode_d = mode_q;
    unique case (req_mode)
      CRD_FULL:    mode_d = CRD_FULL;
      CRD_HALF:    if (half_ok) mode_d = CRD_HALF;
      CRD_QUARTER: if (quart_ok) mode_d = CRD_QUARTER;
      default:     mode_d = mode_q;
    endcase
    if (rst_i)
      mode_d = CRD_FULL;
  end

  // Multiplier follows the next mode so the field never lags
  always_comb
  begin
    mult_d = mult_of(strap_q, mode_d);
    strap_d = strap_q;
    if (rst_i)
    begin
      // Strap caught through a clocked load while reset holds
      strap_d = mult_strap_i;
      mult_d  = MW'(mult_strap_i);
    end
  end

  // Rate state registers, one edge per change
  always_ff @(posedge clk_i)
  begin
    mode_q  <= mode_d;
    mult_q  <= mult_d;
    strap_q <= strap_d;
  end

  // Wishbone: single-cycle ack; the write lands on the edge the master sees ack,
  // so the register never changes ahead of the completed cycle
  always_comb
  begin
    ack_d  = cyc_i && stb_i && !ack_q;
    cfg_d  = cfg_q;
    rdat_d = rdat_q;
    if (ack_q && cyc_i && stb_i && we_i && sel_i[0] && adr_i == `CRD_CFG_OFS)
      cfg_d = dat_i[1:0];
    if (ack_d && !we_i)
    begin
      unique case (adr_i)
        `CRD_CFG_OFS:  rdat_d = {30'h0, cfg_q};
        `CRD_STAT_OFS: rdat_d = {10'h0, strap_q, 2'h0, ~pins_n, 2'h0, mode_q,
                                 {(8-MW){1'b0}}, mult_q};
        `CRD_SUPP_OFS: rdat_d = {30'h0, quart_ok, half_ok};
        default:       rdat_d = 32'h0000_0000;
      endcase
    end
    if (rst_i)
    begin
      ack_d  = 1'b0;
      cfg_d  = `CRD_CFG_RST;
      rdat_d = 32'h0000_0000;
    end
  end

  // Bus registers
  always_ff @(posedge clk_i)
  begin
    ack_q  <= ack_d;
    cfg_q  <= cfg_d;
    rdat_q <= rdat_d;
  end

  assign ack_o                      = ack_q;
  assign dat_o                      = rdat_q;
  assign rate_mode_o                = mode_q;
  assign current_multiplier_field_o = mult_q;

  // Pins both asserted keep the undivided multiplier
  a_both_pins_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_half && pin_quart) |=> (mode_q == CRD_FULL))
    else $error("division active with both pins asserted");

  // Pin half request beats a software quarter request
  a_pin_over_sw: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_half && !pin_quart && cfg_q[1] && half_ok) |=> (mode_q == CRD_HALF))
    else $error("software bit overrode pin request");

  // Supported half request lands one edge later
  a_half_enter: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mode == CRD_HALF && half_ok) |=> (mode_q == CRD_HALF))
    else $error("half mode not entered in one cycle");

  // Quarter request lands one edge later when offered
  a_quart_enter: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mode == CRD_QUARTER && quart_ok) |=> (mode_q == CRD_QUARTER))
    else $error("quarter mode not entered in one cycle");

  // Dropping all requests restores full rate
  a_full_return: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mode == CRD_FULL) |=> (mode_q == CRD_FULL))
    else $error("full rate not restored");

  // Unsupported quarter keeps the present mode
  a_quart_reject: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mode == CRD_QUARTER && !quart_ok) |=> $stable(mode_q))
    else $error("unsupported quarter changed mode");

  // Unsupported half keeps the present mode
  a_half_reject: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mode == CRD_HALF && !half_ok) |=> $stable(mode_q))
    else $error("unsupported half changed mode");

  // Readback always matches strap and mode
  a_field_match: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (mult_q == mult_of(strap_q, mode_q)))
    else $error("multiplier field out of step");

  // Undivided multiplier equals the strap
  a_strap_full: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_q == CRD_FULL) |-> (mult_q == MW'(strap_q)))
    else $error("full mode multiplier not the strap");

endmodule

// *** verif/crd_board_model.sv ***
// Board control logic model driving the active-low rate request pins
`timescale 1ns/100ps
module crd_board_model (
  // Clock
  input  wire logic clk_i,
  // Requests from the test sequence
  input  wire logic want_half_i,
  input  wire logic want_quarter_i,
  // Active-low request pins
  output logic      half_rate_request_n_o,
  output logic      quarter_rate_request_n_o
);
  // Registered drive; each request input is inverted onto its pin with no check of what the core supports
  always @(posedge clk_i)
  begin
    half_rate_request_n_o    <= ~want_half_i;
    quarter_rate_request_n_o <= ~want_quarter_i;
  end
endmodule

// *** verif/crd_rate_ctrl_tb.sv ***
// Self-checking bench for the rate divider control
`timescale 1ns/100ps
`include "crd_consts.svh"
module crd_rate_ctrl_tb
  import crd_pkg::*;
;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, hp_n, qp_n, w_h, w_q;
  logic [7:0]  adr_i, fld;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o;
  logic [5:0]  strap;
  logic [1:0]  mode;
  int          n_fail, tests_run;

  crd_rate_ctrl #(.QUART_OK_MASK(6'h33)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .half_rate_request_n_i(hp_n), .quarter_rate_request_n_i(qp_n),
    .mult_strap_i(strap), .rate_mode_o(mode), .current_multiplier_field_o(fld));

  crd_board_model brd_u (.clk_i(clk_i), .want_half_i(w_h), .want_quarter_i(w_q),
    .half_rate_request_n_o(hp_n), .quarter_rate_request_n_o(qp_n));

  // 200 MHz core clock
  always #2.5 clk_i = ~clk_i;

  task automatic summarize();
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic cycle; held until ack is sampled, bounded wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    if (k >= 20)
    begin
      n_fail++;
      summarize();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    cmp("read", e, q);
  endtask

  task automatic chk(input crd_mode_type m, input logic [7:0] f);
    #1;
    cmp("mode", {30'h0, m}, {30'h0, mode});
    cmp("field", {24'h0, f}, {24'h0, fld});
  endtask

  // Software request: rate must settle one edge after the write edge
  task automatic sw(input logic [1:0] c, input crd_mode_type m, input logic [7:0] f);
    logic [31:0] q;
    wb(1'b1, `CRD_CFG_OFS, {30'h0, c}, q);
    @(posedge clk_i);
    chk(m, f);
  endtask

  // Pin request: model register plus synchroniser before the rate edge
  task automatic pin(input logic h, input logic qr, input crd_mode_type m, input logic [7:0] f);
    @(posedge clk_i);
    w_h <= h;
    w_q <= qr;
    repeat (6) @(posedge clk_i);
    chk(m, f);
  endtask

  task automatic do_reset(input logic [5:0] s);
    strap <= s;
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // Strap 0C: half offered, quarter not; strap 13: both offered
  initial
  begin
    {clk_i, cyc_i, stb_i, we_i, w_h, w_q, n_fail, tests_run} = '0;
    {adr_i, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    strap = 6'h0C;
    do_reset(6'h0C);
    chk(CRD_FULL, 8'h0C);
    rd(`CRD_CFG_OFS, 32'h0);
    rd(`CRD_SUPP_OFS, 32'h1);
    rd(8'h10, 32'h0);
    sw(2'h2, CRD_FULL, 8'h0C);
    sw(2'h1, CRD_HALF, 8'h06);
    sw(2'h3, CRD_HALF, 8'h06);
    sw(2'h2, CRD_HALF, 8'h06);
    rd(`CRD_STAT_OFS, 32'h000C0106);
    sw(2'h0, CRD_FULL, 8'h0C);
    pin(1'b1, 1'b0, CRD_HALF, 8'h06);
    pin(1'b0, 1'b0, CRD_FULL, 8'h0C);
    sw(2'h1, CRD_HALF, 8'h06);
    pin(1'b1, 1'b1, CRD_FULL, 8'h0C);
    rd(`CRD_STAT_OFS, 32'h000C300C);
    pin(1'b0, 1'b0, CRD_HALF, 8'h06);
    do_reset(6'h13);
    chk(CRD_FULL, 8'h13);
    rd(`CRD_SUPP_OFS, 32'h3);
    sw(2'h1, CRD_HALF, 8'h09);
    pin(1'b0, 1'b1, CRD_QUARTER, 8'h04);
    pin(1'b1, 1'b0, CRD_HALF, 8'h09);
    pin(1'b0, 1'b0, CRD_HALF, 8'h09);
    sw(2'h2, CRD_QUARTER, 8'h04);
    pin(1'b1, 1'b0, CRD_HALF, 8'h09);
    pin(1'b0, 1'b0, CRD_QUARTER, 8'h04);
    sw(2'h1, CRD_HALF, 8'h09);
    sw(2'h0, CRD_FULL, 8'h13);
    summarize();
  end
endmodule
